//--- src/pecap_top.sv
// pecap_top: capability register bank with local packet steering
// assumes: packet headers and test-port accesses come from logic on core_clk_i
////////////////////////////////////////////////////////////////////
module pecap_top #(
  parameter  int PORT_W = 8,
  parameter  int DEST_W = 16,
  parameter  int OFS_W  = 24,
  parameter  int LUT_AW = 8,
  parameter  int PORTS  = 16,
  localparam int PIDX_W = $clog2(PORTS)
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              pkt_valid_i,
  input  wire logic [3:0]        pkt_ftype_i,
  input  wire logic [7:0]        pkt_hop_i,
  input  wire logic [PORT_W-1:0] pkt_port_i,
  input  wire logic [DEST_W-1:0] pkt_dest_i,
  input  wire logic              pkt_write_i,
  input  wire logic [OFS_W-1:0]  pkt_offset_i,
  input  wire logic              jtag_valid_i,
  input  wire logic              jtag_write_i,
  input  wire logic [OFS_W-1:0]  jtag_offset_i,
  output logic                   jtag_ready_o,
  input  wire logic              lut_wr_i,
  input  wire logic [PIDX_W-1:0] lut_wr_port_i,
  input  wire logic [LUT_AW-1:0] lut_wr_index_i,
  input  wire logic [PORT_W-1:0] lut_wr_egress_i,
  output logic                   rsp_valid_o,
  output logic                   rsp_write_o,
  output logic                   rsp_jtag_o,
  output logic                   rsp_hit_o,
  output logic      [PORT_W-1:0] rsp_port_o,
  output logic      [31:0]       rsp_data_o,
  output logic                   fwd_valid_o,
  output logic      [PORT_W-1:0] fwd_port_o,
  output logic      [DEST_W-1:0] fwd_dest_o
);
  ////////////////////////////////////////////////////////////////////
  // steering and access selection
  logic              pkt_maint;
  logic              pkt_local;
  logic              pkt_fwd;
  logic              jtag_take;
  logic              acc_take;
  logic              acc_write;
  logic              acc_jtag;
  logic [OFS_W-1:0]  acc_ofs;
  logic [PORT_W-1:0] acc_port;
  logic [31:0]       cap_word;
  logic              cap_hit;
  logic [31:0]       rsp_data_d;

  assign pkt_maint = pkt_ftype_i == pecap_pkg::FTYPE_MAINT;
  // hop count 0 ends the journey here for maintenance packets only
  assign pkt_local = pkt_valid_i && pkt_maint && (pkt_hop_i == pecap_pkg::HOP_LOCAL);
  // steering never looks at the destination id width
  assign pkt_fwd   = pkt_valid_i && !pkt_local;
  // a local packet access wins over the test port
  assign jtag_take    = jtag_valid_i && !pkt_local;
  assign jtag_ready_o = !pkt_local;
  assign acc_take  = pkt_local || jtag_take;
  assign acc_jtag  = !pkt_local;
  assign acc_write = pkt_local ? pkt_write_i : jtag_write_i;
  assign acc_ofs   = pkt_local ? pkt_offset_i : jtag_offset_i;
  assign acc_port  = pkt_local ? pkt_port_i : '0;
  // write data is dropped, the answer is a bare acknowledge
  assign rsp_data_d = acc_write ? 32'h0000_0000 : cap_word;

  pecap_cap_regs #(
    .OFS_W  (OFS_W),
    .PORT_W (PORT_W)
  ) u_cap (
    .ofs_i  (acc_ofs),
    .port_i (acc_port),
    .jtag_i (acc_jtag),
    .word_o (cap_word),
    .hit_o  (cap_hit)
  );

  ////////////////////////////////////////////////////////////////////
  // route table
  pecap_lut_if #(
    .PIDX_W (PIDX_W),
    .LUT_AW (LUT_AW),
    .PORT_W (PORT_W)
  ) lut_bus ();

  assign lut_bus.rd_en     = pkt_fwd;
  assign lut_bus.rd_port   = pkt_port_i[PIDX_W-1:0];
  assign lut_bus.rd_index  = pkt_dest_i[LUT_AW-1:0];
  assign lut_bus.wr_en     = lut_wr_i;
  assign lut_bus.wr_port   = lut_wr_port_i;
  assign lut_bus.wr_index  = lut_wr_index_i;
  assign lut_bus.wr_egress = lut_wr_egress_i;
  assign fwd_port_o        = lut_bus.rd_egress;

  pecap_route_lut #(
    .PORTS  (PORTS),
    .LUT_AW (LUT_AW),
    .PORT_W (PORT_W)
  ) u_lut (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .lut        (lut_bus.store)
  );

  ////////////////////////////////////////////////////////////////////
  // answer registers
  logic              rsp_valid_q;
  logic              rsp_write_q;
  logic              rsp_jtag_q;
  logic              rsp_hit_q;
  logic [PORT_W-1:0] rsp_port_q;
  logic [31:0]       rsp_data_q;
  logic              fwd_valid_q;
  logic [DEST_W-1:0] fwd_dest_q;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rsp_valid_q <= 1'b0;
      rsp_write_q <= 1'b0;
      rsp_jtag_q  <= 1'b0;
      rsp_hit_q   <= 1'b0;
      rsp_port_q  <= '0;
      rsp_data_q  <= 32'h0000_0000;
    end
    else
    begin
      rsp_valid_q <= acc_take;
      if (acc_take)
      begin
        rsp_write_q <= acc_write;
        rsp_jtag_q  <= acc_jtag;
        rsp_hit_q   <= cap_hit;
        rsp_port_q  <= acc_port;
        rsp_data_q  <= rsp_data_d;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fwd_valid_q <= 1'b0;
      fwd_dest_q  <= '0;
    end
    else
    begin
      fwd_valid_q <= pkt_fwd;
      if (pkt_fwd)
        fwd_dest_q <= pkt_dest_i;
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_write_o = rsp_write_q;
  assign rsp_jtag_o  = rsp_jtag_q;
  assign rsp_hit_o   = rsp_hit_q;
  assign rsp_port_o  = rsp_port_q;
  assign rsp_data_o  = rsp_data_q;
  assign fwd_valid_o = fwd_valid_q;
  assign fwd_dest_o  = fwd_dest_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  logic feat_rd;
  logic link_rd;
  logic any_wr;

  assign feat_rd = acc_take && !acc_write && (acc_ofs == OFS_W'(pecap_pkg::OFS_FEAT));
  assign link_rd = acc_take && !acc_write && (acc_ofs == OFS_W'(pecap_pkg::OFS_LINK));
  assign any_wr  = acc_take && acc_write;

  default clocking ast_cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  AST_NO_BRIDGE : assert property (
    feat_rd |=> rsp_valid_o && !rsp_data_o[pecap_pkg::BIT_BRIDGE])
    else $error("bridge flag not zero");

  AST_NO_ENDPOINT : assert property (
    feat_rd |=> rsp_valid_o && !rsp_data_o[pecap_pkg::BIT_ENDPOINT])
    else $error("endpoint flag not zero");

  AST_NO_LOCAL_CPU : assert property (
    feat_rd |=> rsp_valid_o && !rsp_data_o[pecap_pkg::BIT_LOCAL_CPU])
    else $error("local cpu flag not zero");

  AST_ROUTER_FLAG : assert property (
    feat_rd |=> rsp_hit_o && rsp_data_o[pecap_pkg::BIT_ROUTER])
    else $error("router flag not one");

  AST_LOCAL_MAINT : assert property (
    pkt_valid_i && pkt_ftype_i == 4'h8 && pkt_hop_i == 8'h00
    |=> rsp_valid_o && !rsp_jtag_o && !fwd_valid_o)
    else $error("local maintenance packet not taken by registers");

  AST_MAINT_HOPS_ON : assert property (
    pkt_valid_i && pkt_hop_i != 8'h00 |=> fwd_valid_o)
    else $error("packet with hops left not forwarded");

  AST_MCAST_FLAG : assert property (
    feat_rd |=> rsp_data_o[pecap_pkg::BIT_MCAST])
    else $error("multicast flag not one");

  AST_BRINGUP_FLAG : assert property (
    feat_rd |=> rsp_data_o[pecap_pkg::BIT_BRINGUP])
    else $error("bringup flag not one");

  AST_LARGE_DID : assert property (
    feat_rd |=> rsp_data_o[pecap_pkg::BIT_LARGE_DID])
    else $error("large dest id flag not one");

  AST_FWD_DEST : assert property (
    pkt_fwd |=> fwd_valid_o && fwd_dest_o == $past(pkt_dest_i))
    else $error("forwarded destination lost");

  AST_FWD_ONLY_ASKED : assert property (
    !pkt_fwd |=> !fwd_valid_o)
    else $error("forward without a packet");

  AST_FLIST_FLAG : assert property (
    feat_rd |=> rsp_data_o[pecap_pkg::BIT_FLIST])
    else $error("feature list flag not one");

  AST_ADDR_WIDTHS : assert property (
    feat_rd |=> rsp_data_o[2:0] == 3'h7)
    else $error("address width field not 111");

  AST_FEAT_WORD : assert property (
    feat_rd ##1 feat_rd |=> rsp_data_o == 32'h1000_051F && $stable(rsp_data_o))
    else $error("feature word not fixed");

  AST_LINK_TOTAL : assert property (
    link_rd |=> rsp_data_o[15:8] == 8'h10)
    else $error("link total not 10 hex");

  AST_LINK_UPPER : assert property (
    link_rd |=> rsp_data_o[31:16] == 16'h0000)
    else $error("link word upper half not zero");

  AST_REQ_PORT : assert property (
    link_rd && pkt_local |=> rsp_data_o[7:0] == 8'($past(pkt_port_i)))
    else $error("requesting port not returned");

  AST_JTAG_PORT : assert property (
    link_rd && acc_jtag |=> rsp_jtag_o && rsp_data_o[7:0] == 8'h00)
    else $error("test port read shows a port");

  AST_WRITE_ACK : assert property (
    any_wr |=> rsp_valid_o && rsp_write_o && rsp_data_o == 32'h0000_0000 ##1 (!rsp_valid_o || $past(acc_take)))
    else $error("write not acknowledged");

  AST_WRITE_NO_EFFECT : assert property (
    any_wr ##1 feat_rd |=> rsp_data_o == 32'h1000_051F)
    else $error("write changed the feature word");

  AST_FEAT_RESERVED : assert property (
    feat_rd |=> rsp_data_o[27:11] == 17'h0_0000 && !rsp_data_o[9] && rsp_data_o[7:5] == 3'h0)
    else $error("reserved feature bits not zero");

  AST_FEAT_HIT : assert property (
    feat_rd |=> rsp_valid_o && rsp_hit_o && !rsp_write_o)
    else $error("feature read not answered as a read hit");

  AST_LINK_HIT : assert property (
    link_rd |=> rsp_valid_o && rsp_hit_o && !rsp_write_o)
    else $error("link info read not answered as a read hit");

  AST_PKT_PORT_ECHO : assert property (
    pkt_local |=> rsp_port_o == $past(pkt_port_i) && !rsp_jtag_o)
    else $error("answer does not carry the ingress port");

  AST_JTAG_NO_PORT : assert property (
    jtag_take |=> rsp_valid_o && rsp_jtag_o && rsp_port_o == '0)
    else $error("test port answer carries a port");

  AST_JTAG_HELD_OFF : assert property (
    pkt_valid_i && pkt_ftype_i == 4'h8 && pkt_hop_i == 8'h00 |-> !jtag_ready_o)
    else $error("test port taken beside a local packet");

  AST_JTAG_FREE : assert property (
    !pkt_valid_i |-> jtag_ready_o)
    else $error("test port refused with no packet");

  AST_QUIET_IDLE : assert property (
    !pkt_valid_i && !jtag_valid_i |=> !rsp_valid_o && !fwd_valid_o)
    else $error("answer or forward without a request");

  AST_OTHER_TYPE_FWD : assert property (
    pkt_valid_i && pkt_ftype_i != 4'h8 |=> fwd_valid_o)
    else $error("non maintenance packet not forwarded");

  AST_FWD_NO_ANSWER : assert property (
    pkt_fwd && !jtag_valid_i |=> !rsp_valid_o)
    else $error("forwarded packet answered by the registers");

  AST_UNMAPPED_ZERO : assert property (
    acc_take && !acc_write && acc_ofs != OFS_W'(pecap_pkg::OFS_FEAT) && acc_ofs != OFS_W'(pecap_pkg::OFS_LINK)
    |=> !rsp_hit_o && rsp_data_o == 32'h0000_0000)
    else $error("unmapped offset read not zero");

  AST_WRITE_FROM_JTAG : assert property (
    jtag_take && jtag_write_i |=> rsp_valid_o && rsp_write_o && rsp_data_o == 32'h0000_0000)
    else $error("test port write not acknowledged");

  COV_LINK_READ : cover property (
    link_rd && pkt_local ##1 rsp_valid_o && rsp_hit_o);

  COV_LOCAL_READ : cover property (
    pkt_local && !pkt_write_i ##1 rsp_valid_o && rsp_hit_o);

  COV_JTAG_READ : cover property (
    jtag_take && !jtag_write_i ##1 rsp_valid_o && rsp_jtag_o);

  COV_FORWARD : cover property (
    pkt_fwd ##1 fwd_valid_o);

  COV_JTAG_HELD : cover property (
    jtag_valid_i && pkt_local ##1 jtag_valid_i && jtag_ready_o);
endmodule : pecap_top

//--- src/pecap_pkg.sv
// pecap_pkg: offsets, field positions and fixed values of the capability bank
// assumes: bit 0 of a printed field is the msb of the 32-bit word
package pecap_pkg;
  // register offsets
  localparam logic [23:0] OFS_FEAT       = 24'h00_0010;
  localparam logic [23:0] OFS_LINK       = 24'h00_0014;
  // feature word value after reset
  localparam logic [31:0] FEAT_RST       = 32'h1000_051F;
  // feature word field positions
  localparam int          BIT_BRIDGE     = 31;
  localparam int          BIT_ENDPOINT   = 30;
  localparam int          BIT_LOCAL_CPU  = 29;
  localparam int          BIT_ROUTER     = 28;
  localparam int          BIT_MCAST      = 10;
  localparam int          BIT_BRINGUP    = 8;
  localparam int          BIT_LARGE_DID  = 4;
  localparam int          BIT_FLIST      = 3;
  localparam int          AW_LO          = 0;
  // feature word field values
  localparam logic        FLAG_BRIDGE    = 1'h0;
  localparam logic        FLAG_ENDPOINT  = 1'h0;
  localparam logic        FLAG_LOCAL_CPU = 1'h0;
  localparam logic        FLAG_ROUTER    = 1'h1;
  localparam logic        FLAG_MCAST     = 1'h1;
  localparam logic        FLAG_BRINGUP   = 1'h1;
  localparam logic        FLAG_LARGE_DID = 1'h1;
  localparam logic        FLAG_FLIST     = 1'h1;
  localparam logic [2:0]  AW_ALL         = 3'h7;
  // link info word fields
  localparam int          TOTAL_LO       = 8;
  localparam int          NUM_LO         = 0;
  localparam logic [7:0]  LINK_TOTAL     = 8'h10;
  localparam logic [7:0]  JTAG_PORT_FILL = 8'h00;
  // packet steering
  localparam logic [3:0]  FTYPE_MAINT    = 4'h8;
  localparam logic [7:0]  HOP_LOCAL      = 8'h00;
endpackage : pecap_pkg

//--- src/pecap_lut_if.sv
// pecap_lut_if: lookup and programming path of the per-port route tables
// assumes: one lookup and one table write per cycle at most
interface pecap_lut_if #(
  parameter int PIDX_W = 4,
  parameter int LUT_AW = 8,
  parameter int PORT_W = 8
);
  logic              rd_en;
  logic [PIDX_W-1:0] rd_port;
  logic [LUT_AW-1:0] rd_index;
  logic [PORT_W-1:0] rd_egress;
  logic              wr_en;
  logic [PIDX_W-1:0] wr_port;
  logic [LUT_AW-1:0] wr_index;
  logic [PORT_W-1:0] wr_egress;

  modport client (output rd_en, rd_port, rd_index, wr_en, wr_port, wr_index, wr_egress,
                  input  rd_egress);
  modport store  (input  rd_en, rd_port, rd_index, wr_en, wr_port, wr_index, wr_egress,
                  output rd_egress);
endinterface : pecap_lut_if

//--- src/pecap_route_lut.sv
// pecap_route_lut: one route table per ingress port, registered lookup
// assumes: table contents are written before lookups that use them
module pecap_route_lut #(
  parameter int PORTS  = 16,
  parameter int LUT_AW = 8,
  parameter int PORT_W = 8
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  pecap_lut_if.store lut
);
  localparam int PIDX_W = $clog2(PORTS);

  logic [PORT_W-1:0]        mem [PORTS*(2**LUT_AW)];
  logic [PORT_W-1:0]        egress_q;
  logic [PIDX_W+LUT_AW-1:0] rd_addr;
  logic [PIDX_W+LUT_AW-1:0] wr_addr;

  // the ingress port selects the table
  assign rd_addr       = {lut.rd_port, lut.rd_index};
  assign wr_addr       = {lut.wr_port, lut.wr_index};
  assign lut.rd_egress = egress_q;

  always_ff @(posedge core_clk_i)
  begin
    if (lut.wr_en)
      mem[wr_addr] <= lut.wr_egress;
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      egress_q <= '0;
    else if (lut.rd_en)
      egress_q <= mem[rd_addr];
  end
endmodule : pecap_route_lut

//--- src/pecap_cap_regs.sv
// pecap_cap_regs: fixed feature word and link info word, decoded by offset
// assumes: purely combinational, the caller registers the answer
module pecap_cap_regs #(
  parameter int OFS_W  = 24,
  parameter int PORT_W = 8
) (
  input  wire logic [OFS_W-1:0]  ofs_i,
  input  wire logic [PORT_W-1:0] port_i,
  input  wire logic              jtag_i,
  output logic      [31:0]       word_o,
  output logic                   hit_o
);
  logic [31:0] feat_word;
  logic [31:0] link_word;
  logic [7:0]  req_port;
  logic        is_feat;
  logic        is_link;

  // feature word built from constant flags only
  assign feat_word = ({31'h0000_0000, pecap_pkg::FLAG_BRIDGE}    << pecap_pkg::BIT_BRIDGE)
                   | ({31'h0000_0000, pecap_pkg::FLAG_ENDPOINT}  << pecap_pkg::BIT_ENDPOINT)
                   | ({31'h0000_0000, pecap_pkg::FLAG_LOCAL_CPU} << pecap_pkg::BIT_LOCAL_CPU)
                   | ({31'h0000_0000, pecap_pkg::FLAG_ROUTER}    << pecap_pkg::BIT_ROUTER)
                   | ({31'h0000_0000, pecap_pkg::FLAG_MCAST}     << pecap_pkg::BIT_MCAST)
                   | ({31'h0000_0000, pecap_pkg::FLAG_BRINGUP}   << pecap_pkg::BIT_BRINGUP)
                   | ({31'h0000_0000, pecap_pkg::FLAG_LARGE_DID} << pecap_pkg::BIT_LARGE_DID)
                   | ({31'h0000_0000, pecap_pkg::FLAG_FLIST}     << pecap_pkg::BIT_FLIST)
                   | ({29'h0000_0000, pecap_pkg::AW_ALL}         << pecap_pkg::AW_LO);
  // requesting port, fixed fill on the test port
  assign req_port  = jtag_i ? pecap_pkg::JTAG_PORT_FILL : 8'(port_i);
  assign link_word = ({24'h00_0000, pecap_pkg::LINK_TOTAL} << pecap_pkg::TOTAL_LO)
                   | ({24'h00_0000, req_port} << pecap_pkg::NUM_LO);
  assign is_feat   = ofs_i == OFS_W'(pecap_pkg::OFS_FEAT);
  assign is_link   = ofs_i == OFS_W'(pecap_pkg::OFS_LINK);
  assign hit_o     = is_feat | is_link;
  assign word_o    = is_feat ? feat_word : (is_link ? link_word : 32'h0000_0000);
endmodule : pecap_cap_regs

//--- verification/pecap_jtag_host.sv
// pecap_jtag_host: test-port requester on the far side of the capability bank
// assumes: runs on core_clk_i, samples ready on the rising edge
module pecap_jtag_host (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic [23:0] ofs_i,
  input  wire logic [1:0]  dly_i,
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic             write_o,
  output logic      [23:0] ofs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend_q;
  logic [1:0] cnt_q;
  ////////////////////////////////////////////////////////////////////
  // request held until ready is seen high, then lines show the inverse
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      valid_o <= 1'b0;
      write_o <= 1'b0;
      ofs_o   <= 24'h00_0000;
      pend_q  <= 1'b0;
      cnt_q   <= 2'h0;
    end
    else if (valid_o && ready_i)
    begin
      valid_o <= 1'b0;
      write_o <= ~write_o;
      ofs_o   <= ~ofs_o;
    end
    else if (pend_q && cnt_q == 2'h0)
    begin
      valid_o <= 1'b1;
      pend_q  <= 1'b0;
    end
    else if (pend_q)
      cnt_q <= cnt_q - 2'h1;
    else if (!valid_o && go_i)
    begin
      pend_q  <= 1'b1;
      cnt_q   <= dly_i;
      write_o <= wr_i;
      ofs_o   <= ofs_i;
    end
  end
endmodule : pecap_jtag_host

//--- verification/test_pecap_top.sv
// test_pecap_top: self-checking bench of the capability bank
// assumes: 40 MHz clock, random stimulus from a fixed seed
module test_pecap_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i, reset_i, pkt_valid_i, pkt_write_i, lut_wr_i, j_go, j_wr;
  logic        jtag_valid, jtag_write, jtag_ready, rsp_valid, rsp_write, rsp_jtag, rsp_hit, fwd_valid;
  logic [1:0]  j_dly;
  logic [3:0]  pkt_ftype_i, lut_wr_port_i, ft;
  logic [7:0]  pkt_hop_i, pkt_port_i, lut_wr_index_i, lut_wr_egress_i, rsp_port, fwd_port, hop;
  logic [15:0] pkt_dest_i, fwd_dest;
  logic [23:0] pkt_offset_i, j_ofs, jtag_offset, ofs, fexp[$];
  logic [31:0] rsp_data;
  logic [41:0] jexp;
  logic [42:0] rexp[$];
  logic [7:0]  lutm[16][256];
  int          rdue[$], fdue[$], cyc, jseen, n_mismatch, tests_run;

  pecap_top i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .pkt_valid_i(pkt_valid_i),
    .pkt_ftype_i(pkt_ftype_i), .pkt_hop_i(pkt_hop_i), .pkt_port_i(pkt_port_i), .pkt_dest_i(pkt_dest_i),
    .pkt_write_i(pkt_write_i), .pkt_offset_i(pkt_offset_i), .jtag_valid_i(jtag_valid),
    .jtag_write_i(jtag_write), .jtag_offset_i(jtag_offset), .jtag_ready_o(jtag_ready), .lut_wr_i(lut_wr_i),
    .lut_wr_port_i(lut_wr_port_i), .lut_wr_index_i(lut_wr_index_i), .lut_wr_egress_i(lut_wr_egress_i),
    .rsp_valid_o(rsp_valid), .rsp_write_o(rsp_write), .rsp_jtag_o(rsp_jtag), .rsp_hit_o(rsp_hit),
    .rsp_port_o(rsp_port), .rsp_data_o(rsp_data), .fwd_valid_o(fwd_valid), .fwd_port_o(fwd_port),
    .fwd_dest_o(fwd_dest));
  pecap_jtag_host i_host (.clk_i(core_clk_i), .reset_i(reset_i), .go_i(j_go), .wr_i(j_wr), .ofs_i(j_ofs),
    .dly_i(j_dly), .ready_i(jtag_ready), .valid_o(jtag_valid), .write_o(jtag_write), .ofs_o(jtag_offset));

  always #12.5 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_word(logic [23:0] o, logic [7:0] p, logic jt, logic wr);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (!wr && o == 24'h00_0010)
      for (int b = 0; b < 32; b++) w[31-b] = (b inside {3, 21, 23, 27, 28, 29, 30, 31});
    if (!wr && o == 24'h00_0014)
      w = {16'h0000, 8'h10, jt ? 8'h00 : p};
    return w;
  endfunction : exp_word

  function automatic logic [7:0] idx_of(int k);
    return (k == 7) ? 8'hFF : 8'(k);
  endfunction : idx_of

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////
  task automatic send(input logic [3:0] f, input logic [7:0] h, input logic [7:0] p,
                      input logic [15:0] d, input logic wr, input logic [23:0] o);
    logic loc;
    loc = (f == 4'h8 && h == 8'h00);
    pkt_valid_i  <= 1'b1;
    pkt_ftype_i  <= f;
    pkt_hop_i    <= h;
    pkt_port_i   <= p;
    pkt_dest_i   <= d;
    pkt_write_i  <= wr;
    pkt_offset_i <= o;
    lut_wr_i     <= 1'b0;
    if (loc)
    begin
      rdue.push_back(cyc + 1);
      rexp.push_back({wr, 1'b0, o == 24'h00_0010 || o == 24'h00_0014, p, exp_word(o, p, 1'b0, wr)});
    end
    else
    begin
      fdue.push_back(cyc + 1);
      fexp.push_back({lutm[p[3:0]][d[7:0]], d});
    end
    @(negedge core_clk_i);
    check(jtag_ready, !loc);
    @(posedge core_clk_i);
  endtask : send

  task automatic lutw(input logic [3:0] p, input logic [7:0] i, input logic [7:0] e);
    pkt_valid_i     <= 1'b0;
    lut_wr_i        <= 1'b1;
    lut_wr_port_i   <= p;
    lut_wr_index_i  <= i;
    lut_wr_egress_i <= e;
    lutm[p][i] = e;
    @(posedge core_clk_i);
  endtask : lutw

  task automatic idle();
    pkt_valid_i <= 1'b0;
    lut_wr_i    <= 1'b0;
    @(posedge core_clk_i);
  endtask : idle

  task automatic jtag_op(input logic wr, input logic [23:0] o, input logic pk);
    int j0;
    j0 = jseen;
    jexp = {wr, o == 24'h00_0010 || o == 24'h00_0014, 8'h00, exp_word(o, 8'h00, 1'b1, wr)};
    pkt_valid_i <= 1'b0;
    j_go <= 1'b1;
    j_wr <= wr;
    j_ofs <= o;
    j_dly <= pk ? 2'h0 : 2'($urandom);
    @(posedge core_clk_i);
    j_go <= 1'b0;
    @(posedge core_clk_i);
    if (pk)
      send(4'h8, 8'h00, 8'h05, 16'h0000, 1'b0, 24'h00_0010);
    idle();
    for (int n = 0; n < 20 && jseen == j0; n++) @(posedge core_clk_i);
    if (jseen == j0)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : jtag_op
  ////////////////////////////////////////////////////////////////////
  always @(negedge core_clk_i)
  begin
    if (!reset_i)
    begin
      if (rsp_valid === 1'b1 && rsp_jtag === 1'b1)
      begin
        check({rsp_write, rsp_hit, rsp_port, rsp_data}, jexp);
        jseen++;
      end
      else if (rdue.size() > 0 && rdue[0] == cyc)
      begin
        check({rsp_valid, rsp_write, rsp_jtag, rsp_hit, rsp_port, rsp_data}, {1'b1, rexp.pop_front()});
        void'(rdue.pop_front());
      end
      else
        check(rsp_valid, 1'b0);
      if (fdue.size() > 0 && fdue[0] == cyc)
      begin
        check({fwd_valid, fwd_port, fwd_dest}, {1'b1, fexp.pop_front()});
        void'(fdue.pop_front());
      end
      else
        check(fwd_valid, 1'b0);
    end
    cyc++;
  end

  initial
  begin
    core_clk_i = 1'b0;
    reset_i = 1'b1;
    {pkt_valid_i, pkt_write_i, lut_wr_i, j_go, j_wr, j_dly, pkt_ftype_i, pkt_hop_i, pkt_port_i} = '0;
    {pkt_dest_i, pkt_offset_i, j_ofs, lut_wr_port_i, lut_wr_index_i, lut_wr_egress_i} = '0;
    void'($urandom(50));
    repeat (5) @(posedge core_clk_i);
    check({rsp_valid, fwd_valid, rsp_data}, 34'h0_0000_0000);
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    for (int p = 0; p < 16; p++)
      for (int k = 0; k < 8; k++) lutw(4'(p), idx_of(k), 8'($urandom));
    check(rdue.size() + fdue.size(), 0);
    for (int k = 0; k < 3; k++)
    begin
      send(4'h8, 8'h00, idx_of(k * 7 / 2), 16'h0000, 1'b0, 24'h00_0010);
      send(4'h8, 8'h00, idx_of(k * 7 / 2), 16'h0000, 1'b0, 24'h00_0014);
      send(4'h8, 8'h00, 8'h0F, 16'h0000, 1'b1, 24'h00_0010 + 24'(k * 4));
      send(4'h8, 8'h01, 8'h0F, 16'h00FF, 1'b0, 24'h00_0010);
      send(4'($urandom % 8), 8'h00, 8'h03, 16'hAB00 + 16'(k), 1'b0, 24'h00_0010);
    end
    lutw(4'h3, 8'h01, 8'hC3);
    send(4'h2, 8'h07, 8'h13, 16'h5501, 1'b0, 24'h00_0000);
    send(4'h8, 8'h00, 8'h44, 16'h0000, 1'b0, 24'h00_0000);
    for (int k = 0; k < 6; k++) jtag_op(k[0], 24'h00_0010 + 24'(4 * (k / 2)), k == 0);
    for (int n = 0; n < 400; n++)
    begin
      ft = ($urandom % 2) ? 4'h8 : 4'($urandom);
      hop = ($urandom % 2) ? 8'h00 : 8'($urandom);
      ofs = ($urandom % 5 == 0) ? 24'($urandom) : 24'h00_0010 + 24'(4 * ($urandom % 3));
      send(ft, hop, 8'($urandom), {8'($urandom), idx_of($urandom % 8)}, $urandom % 4 == 0, ofs);
      if ($urandom % 4 == 0)
        idle();
    end
    idle();
    repeat (3) @(posedge core_clk_i);
    check(rdue.size() + fdue.size(), 0);
    stop_test();
  end
endmodule : test_pecap_top
